// [hdl/usb_in_ep_defs.svh]
// register offsets, field positions and reset values of the in endpoint descriptor
`ifndef USB_IN_EP_DEFS_SVH
`define USB_IN_EP_DEFS_SVH
`define IEP_OFS_SIZE    8'h00
`define IEP_OFS_XBASE   8'h04
`define IEP_OFS_SETUP   8'h08
`define IEP_OFS_YBASE   8'h0C
`define IEP_OFS_XCOUNT  8'h10
`define IEP_OFS_YCOUNT  8'h14
`define IEP_OFS_STATUS  8'h18
`define IEP_OFS_MASK    8'h1C
`define IEP_BIT_ON      7
`define IEP_BIT_ISO     6
`define IEP_BIT_TOGGLE  5
`define IEP_BIT_OVERRUN 5
`define IEP_BIT_DUAL    4
`define IEP_BIT_STALL   3
`define IEP_BIT_IRQ_ON  2
`define IEP_BIT_EMPTY   7
`define IEP_ST_DONE     0
`define IEP_ST_OVERRUN  1
`define IEP_ST_STALL    2
`define IEP_UNIT_SHIFT  3
`define IEP_RST_BYTE    8'h00
`define IEP_RST_IRQ     3'h0
`endif

// [hdl/usb_in_ep_pkg.sv]
// types shared by the in endpoint descriptor logic
package usb_in_ep_pkg;
  typedef enum logic [0:0] {
    ST_IDLE     = 1'b0,
    ST_WAIT_ACK = 1'b1
  } ep_state_t;
endpackage

// [hdl/usb_in_endpoint_descriptor.sv]
// in endpoint descriptor registers and buffer manager decisions behind an apb slave
// Functional notes
// - buffer length in bytes is the size byte times eight
// - one size byte gives x and y buffers the same length
// - x start address is 11 bits, start byte gives bits 10 to 3
// - low three start address bits are zero, buffers on 8-byte boundaries
// - setup bit 7 enables the endpoint, zero disables it
// - setup tokens are accepted whatever the enable bit says
// - setup bit 6 selects isochronous mode and remaps bits 5 to 0
// - bit 5 toggles after each acknowledged data stage, picks DATA0 or DATA1
// - bit 4 selects double buffering, otherwise only x buffer used
// - bit 3 set makes every transaction answer with stall; here setup tokens are still accepted
// - bit 2 lets the endpoint interrupt reach the processor
// - bits 1 and 0 are stored but have no effect in non-iso mode
// - iso mode: buffer overflow sets bit 5, diagnostic only
// - overflow flag stays set until software writes it to zero
// - iso mode: bits 4 to 0 give bytes per sample, code plus one
// - 7-bit count is bytes, or samples times bytes per sample in iso
// - iso endpoints never nack and ignore the buffer empty flag
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "usb_in_ep_defs.svh"

module usb_in_endpoint_descriptor #(
  parameter int APB_AW = 8
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_rstn,
  input  wire logic              i_ce,
  input  wire logic [APB_AW-1:0] i_paddr,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_in_token,
  input  wire logic              i_setup_token,
  input  wire logic              i_in_ack,
  input  wire logic              i_iso_overflow,
  output logic                   o_send_data,
  output logic                   o_send_nack,
  output logic                   o_send_stall,
  output logic                   o_setup_accept,
  output logic                   o_data1,
  output logic                   o_buf_is_y,
  output logic [10:0]            o_buf_start,
  output logic [10:0]            o_buf_length,
  output logic [11:0]            o_tx_bytes,
  output logic                   o_irq
);

  // elaboration check: the map needs at least five address bits
  if (APB_AW < 5) begin : g_bad_aw
    $error("apb address width too small");
  end

  // operating notes for whoever integrates this endpoint
  // - every descriptor byte sits in bits 7:0 of its own aligned word
  // - only byte lane 0 carries data; a write with that strobe low is dropped
  // - an unmapped offset answers with pslverr, reads zero and drops writes
  // - read data is loaded in the setup phase and stands until the next read
  // - pready follows the clock enable, so a running block adds no wait state
  // - with the clock enable low every flop holds, response strobes included
  // - a strobe held by a frozen enable therefore stands for more than a cycle
  // - the token, ack and overflow inputs come from logic on this clock,
  //   so they are taken without synchronising flops
  // - each token gets one strobe on the following edge, except an in token to a disabled endpoint without stall
  // - a setup token wins over an in token arriving in the same cycle
  // - a disabled endpoint stays silent on in tokens unless stall is set
  // - stall outranks everything else on an in token outside iso mode
  // - an ack is ignored unless a data packet is waiting for it
  // - an ack in the same cycle as a token is dropped; the host cannot send both
  // - a retried in token while waiting resends the same buffer and pid
  // - the empty flag of a count byte is set by hardware after an ack
  //   and only software clears it; until then the endpoint answers nack on that buffer
  // - iso endpoints ignore the empty flag, never nack and never wait for ack
  // - iso mode alternates x and y on every in token it answers; the dual bit is sample size
  // - iso packets always carry the data0 pid
  // - the overflow flag lives in the setup byte itself; in iso mode a write
  //   can only clear it, never set it; only the write that enters iso mode can set it
  // - an overflow in the same cycle as a clearing write leaves the flag set
  // - hardware toggle and empty updates likewise win over same-cycle writes
  // - switching between iso and bulk mode reinterprets the stored low bits, so
  //   software should rewrite the whole setup byte when it changes mode
  // - clearing the enable bit returns the buffer choice to x and goes idle
  // - buffer length is the size byte times eight and is shared by x and y
  // - start addresses are eleven bits with three zero low bits
  // - the block does not check that buffers fit or stay apart; software must
  // - the transmit length is at most 127 samples of 32 bytes, so 12 bits do
  // - interrupt status bits: done, overflow and stall sent, all write one
  //   to clear, with a mask register of the same layout
  // - the done bit also needs the endpoint irq enable outside iso mode
  // - the interrupt output is a level, high while an unmasked bit is set

  // descriptor and control state
  logic [7:0]                size_byte;
  logic [7:0]                x_start_byte;
  logic [7:0]                y_start_byte;
  logic [7:0]                setup_byte;
  logic [7:0]                x_count_byte;
  logic [7:0]                y_count_byte;
  logic [2:0]                irq_status;
  logic [2:0]                irq_mask;
  logic                      buf_sel;
  usb_in_ep_pkg::ep_state_t  state;
  logic [31:0]               rd_data;
  logic                      send_p;
  logic                      nack_p;
  logic                      stall_p;
  logic                      setup_p;
  logic                      data1_q;
  logic                      is_y_q;
  logic [10:0]               start_q;
  logic [11:0]               bytes_q;

  // next values
  logic [7:0]                next_size_byte;
  logic [7:0]                next_x_start_byte;
  logic [7:0]                next_y_start_byte;
  logic [7:0]                next_setup_byte;
  logic [7:0]                next_x_count_byte;
  logic [7:0]                next_y_count_byte;
  logic [2:0]                next_irq_status;
  logic [2:0]                next_irq_mask;
  logic                      next_buf_sel;
  usb_in_ep_pkg::ep_state_t  next_state;
  logic [31:0]               next_rd_data;
  logic                      next_send_p;
  logic                      next_nack_p;
  logic                      next_stall_p;
  logic                      next_setup_p;
  logic                      next_data1_q;
  logic                      next_is_y_q;
  logic [10:0]               next_start_q;
  logic [11:0]               next_bytes_q;

  // decoded fields
  logic                      ep_on;
  logic                      iso_mode;
  logic                      stall_on;
  logic                      dual_on;
  logic [4:0]                sample_frame_bytes;
  logic [7:0]                cur_count;
  logic [11:0]               cur_bytes;
  logic [10:0]               cur_start;
  logic                      addr_hit;
  logic                      wr_en;
  logic [7:0]                wbyte;
  logic [7:0]                offset;
  logic [2:0]                irq_gate;

  assign offset   = 8'(i_paddr);
  assign wbyte    = i_pstrb[0] ? i_pwdata[7:0] : 8'h00;
  assign wr_en    = i_psel && i_penable && i_pwrite && i_pstrb[0];

  assign ep_on              = setup_byte[`IEP_BIT_ON];
  assign iso_mode           = setup_byte[`IEP_BIT_ISO];
  assign stall_on           = !iso_mode && setup_byte[`IEP_BIT_STALL];
  assign dual_on            = !iso_mode && setup_byte[`IEP_BIT_DUAL];
  // bits 1 and 0 are only stored; nothing reads them outside iso mode
  assign sample_frame_bytes = setup_byte[4:0];

  // buffer of the current transaction and its length
  assign cur_count = buf_sel ? y_count_byte : x_count_byte;
  assign cur_start = buf_sel ? {y_start_byte, 3'h0} : {x_start_byte, 3'h0};
  assign cur_bytes = iso_mode ?
                     (12'(cur_count[6:0]) * (12'(sample_frame_bytes) + 12'h001)) :
                     12'(cur_count[6:0]);

  // address decode of the mapped words
  always_comb begin
    unique case (offset)
      `IEP_OFS_SIZE,   `IEP_OFS_XBASE,  `IEP_OFS_SETUP,
      `IEP_OFS_YBASE,  `IEP_OFS_XCOUNT, `IEP_OFS_YCOUNT,
      `IEP_OFS_STATUS, `IEP_OFS_MASK:  addr_hit = 1'b1;
      default:                         addr_hit = 1'b0;
    endcase
  end

  // next state of registers, buffer manager and response strobes
  always_comb begin
    next_size_byte    = size_byte;
    next_x_start_byte = x_start_byte;
    next_y_start_byte = y_start_byte;
    next_setup_byte   = setup_byte;
    next_x_count_byte = x_count_byte;
    next_y_count_byte = y_count_byte;
    next_irq_status   = irq_status;
    next_irq_mask     = irq_mask;
    next_buf_sel      = buf_sel;
    next_state        = state;
    next_rd_data      = rd_data;
    next_send_p       = 1'b0;
    next_nack_p       = 1'b0;
    next_stall_p      = 1'b0;
    next_setup_p      = 1'b0;
    next_data1_q      = data1_q;
    next_is_y_q       = is_y_q;
    next_start_q      = start_q;
    next_bytes_q      = bytes_q;

    // read data captured in the setup phase
    if (i_psel && !i_penable && !i_pwrite) begin
      unique case (offset)
        `IEP_OFS_SIZE:   next_rd_data = {24'h000000, size_byte};
        `IEP_OFS_XBASE:  next_rd_data = {24'h000000, x_start_byte};
        `IEP_OFS_SETUP:  next_rd_data = {24'h000000, setup_byte};
        `IEP_OFS_YBASE:  next_rd_data = {24'h000000, y_start_byte};
        `IEP_OFS_XCOUNT: next_rd_data = {24'h000000, x_count_byte};
        `IEP_OFS_YCOUNT: next_rd_data = {24'h000000, y_count_byte};
        `IEP_OFS_STATUS: next_rd_data = {29'h00000000, irq_status};
        `IEP_OFS_MASK:   next_rd_data = {29'h00000000, irq_mask};
        default:         next_rd_data = 32'h00000000;
      endcase
    end

    // software writes, hardware events below take priority
    if (wr_en) begin
      unique case (offset)
        `IEP_OFS_SIZE:   next_size_byte    = wbyte;
        `IEP_OFS_XBASE:  next_x_start_byte = wbyte;
        `IEP_OFS_YBASE:  next_y_start_byte = wbyte;
        `IEP_OFS_XCOUNT: next_x_count_byte = wbyte;
        `IEP_OFS_YCOUNT: next_y_count_byte = wbyte;
        `IEP_OFS_MASK:   next_irq_mask     = wbyte[2:0];
        `IEP_OFS_STATUS: next_irq_status   = irq_status & ~wbyte[2:0];
        `IEP_OFS_SETUP: begin
          next_setup_byte = wbyte;
          if (iso_mode) begin
            // overflow flag may only be cleared by a zero write
            next_setup_byte[`IEP_BIT_OVERRUN] =
              setup_byte[`IEP_BIT_OVERRUN] & wbyte[`IEP_BIT_OVERRUN];
          end
        end
        default: ;
      endcase
    end

    // setup token never depends on enable
    if (i_setup_token) begin
      next_setup_p = 1'b1;
      next_state   = usb_in_ep_pkg::ST_IDLE;
    end else if (i_in_token) begin
      if (stall_on) begin
        next_stall_p                  = 1'b1;
        next_irq_status[`IEP_ST_STALL] = 1'b1;
      end else if (ep_on) begin
        if (iso_mode) begin
          // iso: always send, alternate buffers, never nack
          next_send_p  = 1'b1;
          next_data1_q = 1'b0;
          next_is_y_q  = buf_sel;
          next_start_q = cur_start;
          next_bytes_q = cur_bytes;
          next_buf_sel = !buf_sel;
        end else if (cur_count[`IEP_BIT_EMPTY]) begin
          next_nack_p = 1'b1;
        end else begin
          next_send_p  = 1'b1;
          next_data1_q = setup_byte[`IEP_BIT_TOGGLE];
          next_is_y_q  = buf_sel;
          next_start_q = cur_start;
          next_bytes_q = cur_bytes;
          next_state   = usb_in_ep_pkg::ST_WAIT_ACK;
        end
      end
    end

    // acknowledged data stage closes the buffer
    if (i_in_ack && !i_setup_token && !i_in_token &&
        state == usb_in_ep_pkg::ST_WAIT_ACK && !iso_mode) begin
      next_setup_byte[`IEP_BIT_TOGGLE] = !setup_byte[`IEP_BIT_TOGGLE];
      if (buf_sel) begin
        next_y_count_byte[`IEP_BIT_EMPTY] = 1'b1;
      end else begin
        next_x_count_byte[`IEP_BIT_EMPTY] = 1'b1;
      end
      next_irq_status[`IEP_ST_DONE] = 1'b1;
      next_buf_sel = dual_on ? !buf_sel : 1'b0;
      next_state   = usb_in_ep_pkg::ST_IDLE;
    end

    // overflow marks the flag, set wins over a clearing write
    if (iso_mode && i_iso_overflow) begin
      next_setup_byte[`IEP_BIT_OVERRUN] = 1'b1;
      next_irq_status[`IEP_ST_OVERRUN]  = 1'b1;
    end

    // disabled endpoint restarts on the x buffer
    if (!next_setup_byte[`IEP_BIT_ON]) begin
      next_buf_sel = 1'b0;
      next_state   = usb_in_ep_pkg::ST_IDLE;
    end
  end

  // registers, frozen while the clock enable is low
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      size_byte    <= `IEP_RST_BYTE;
      x_start_byte <= `IEP_RST_BYTE;
      y_start_byte <= `IEP_RST_BYTE;
      setup_byte   <= `IEP_RST_BYTE;
      x_count_byte <= `IEP_RST_BYTE;
      y_count_byte <= `IEP_RST_BYTE;
      irq_status   <= `IEP_RST_IRQ;
      irq_mask     <= `IEP_RST_IRQ;
      buf_sel      <= 1'b0;
      state        <= usb_in_ep_pkg::ST_IDLE;
      rd_data      <= 32'h00000000;
      send_p       <= 1'b0;
      nack_p       <= 1'b0;
      stall_p      <= 1'b0;
      setup_p      <= 1'b0;
      data1_q      <= 1'b0;
      is_y_q       <= 1'b0;
      start_q      <= 11'h000;
      bytes_q      <= 12'h000;
    end else if (i_ce) begin
      size_byte    <= next_size_byte;
      x_start_byte <= next_x_start_byte;
      y_start_byte <= next_y_start_byte;
      setup_byte   <= next_setup_byte;
      x_count_byte <= next_x_count_byte;
      y_count_byte <= next_y_count_byte;
      irq_status   <= next_irq_status;
      irq_mask     <= next_irq_mask;
      buf_sel      <= next_buf_sel;
      state        <= next_state;
      rd_data      <= next_rd_data;
      send_p       <= next_send_p;
      nack_p       <= next_nack_p;
      stall_p      <= next_stall_p;
      setup_p      <= next_setup_p;
      data1_q      <= next_data1_q;
      is_y_q       <= next_is_y_q;
      start_q      <= next_start_q;
      bytes_q      <= next_bytes_q;
    end
  end

  // done interrupt only passes with the endpoint irq enable in non-iso mode
  assign irq_gate = {1'b1, 1'b1, iso_mode | setup_byte[`IEP_BIT_IRQ_ON]};

  // per-bit pending: status set, unmasked and gate open
  logic [2:0]                irq_pend;
  for (genvar b = 0; b < 3; b++) begin : g_irq_bit
    assign irq_pend[b] = irq_status[b] & irq_mask[b] & irq_gate[b];
  end

  // apb answer, zero wait unless frozen
  assign o_pready  = i_ce;
  assign o_pslverr = i_psel && i_penable && !addr_hit;
  assign o_prdata  = rd_data;

  // buffer manager outputs
  assign o_send_data    = send_p;
  assign o_send_nack    = nack_p;
  assign o_send_stall   = stall_p;
  assign o_setup_accept = setup_p;
  assign o_data1        = data1_q;
  assign o_buf_is_y     = is_y_q;
  assign o_buf_start    = start_q;
  assign o_buf_length   = {size_byte, 3'h0};
  assign o_tx_bytes     = bytes_q;
  assign o_irq          = |irq_pend;

endmodule // usb_in_endpoint_descriptor

// [sim/usb_host_model.sv]
// usb host stand-in: token, ack and overflow pulses towards the endpoint
`timescale 1ns/1ps
module usb_host_model (
  input  wire logic i_clk_sys,
  output logic      o_in_token     = 1'b0,
  output logic      o_setup_token  = 1'b0,
  output logic      o_in_ack       = 1'b0,
  output logic      o_iso_overflow = 1'b0
);
  // one-cycle pulse after an edge: 0 in, 1 setup, 2 ack, 3 overflow
  task automatic pulse(input int k);
    @(posedge i_clk_sys);
    o_in_token     <= (k == 0);
    o_setup_token  <= (k == 1);
    o_in_ack       <= (k == 2);
    o_iso_overflow <= (k == 3);
    @(posedge i_clk_sys);
    o_in_token     <= 1'b0;
    o_setup_token  <= 1'b0;
    o_in_ack       <= 1'b0;
    o_iso_overflow <= 1'b0;
  endtask
endmodule // usb_host_model

// [sim/usb_in_ep_asserts.sv]
// port checker for the in endpoint descriptor
`timescale 1ns/1ps
module usb_in_ep_asserts (
  input wire logic        i_clk_sys,
  input wire logic        i_rstn,
  input wire logic        i_ce,
  input wire logic        i_psel,
  input wire logic        i_in_token,
  input wire logic        i_setup_token,
  input wire logic        i_in_ack,
  input wire logic        i_iso_overflow,
  input wire logic        o_send_data,
  input wire logic        o_send_nack,
  input wire logic        o_send_stall,
  input wire logic        o_setup_accept,
  input wire logic        o_data1,
  input wire logic [10:0] o_buf_start,
  input wire logic [10:0] o_buf_length,
  input wire logic        o_irq
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  logic sent;
  logic acked;
  logic last;
  // whether a packet was sent and whether the host acked it; bus traffic forgets both
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn || i_psel) begin
      sent  <= 1'b0;
      acked <= 1'b0;
    end else if (o_send_data) begin
      sent  <= 1'b1;
      acked <= 1'b0;
    end else if (i_in_ack && i_ce) begin
      acked <= 1'b1;
    end
  end
  // pid of the packet just sent
  always_ff @(posedge i_clk_sys) begin
    if (o_send_data) begin
      last <= o_data1;
    end
  end
  a_len_units: assert property (o_buf_length[2:0] == 3'h0)
    else $error("buffer length not in 8-byte units");
  a_start_units: assert property (o_buf_start[2:0] == 3'h0)
    else $error("buffer start not 8-byte aligned");
  a_setup_taken: assert property (i_ce && i_setup_token |=> o_setup_accept)
    else $error("setup token not accepted");
  a_reply_cause: assert property (o_send_data || o_send_nack || o_send_stall |-> $past(i_in_token))
    else $error("reply without in token");
  a_stall_alone: assert property (o_send_stall |-> !o_send_data && !o_send_nack)
    else $error("stall with another reply");
  a_setup_first: assert property (o_setup_accept |-> !o_send_data)
    else $error("data sent with setup accept");
  a_toggle_flip: assert property (o_send_data && sent |-> o_data1 == (last ^ acked))
    else $error("data pid toggle wrong");
  a_irq_cause: assert property (!$stable(o_irq) |-> $past(i_psel) || $past(i_in_ack)
    || $past(i_in_token) || $past(i_iso_overflow))
    else $error("interrupt moved without cause");
  c_data1: cover property (o_send_data && o_data1);
  c_stall: cover property (o_send_stall);
  c_nack: cover property (o_send_nack);
  c_irq: cover property ($rose(o_irq));
endmodule // usb_in_ep_asserts

bind usb_in_endpoint_descriptor usb_in_ep_asserts u_chk (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(i_ce), .i_psel(i_psel),
  .i_in_token(i_in_token), .i_setup_token(i_setup_token), .i_in_ack(i_in_ack),
  .i_iso_overflow(i_iso_overflow), .o_send_data(o_send_data), .o_send_nack(o_send_nack),
  .o_send_stall(o_send_stall), .o_setup_accept(o_setup_accept), .o_data1(o_data1),
  .o_buf_start(o_buf_start), .o_buf_length(o_buf_length), .o_irq(o_irq));

// [sim/testbench.sv]
// self-checking bench for the in endpoint descriptor
`timescale 1ns/1ps
`include "usb_in_ep_defs.svh"
module testbench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pw = 1'b0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] prd;
  logic [31:0] rd;
  logic        prdy, perr, err, tk, st, ak, ov, sd, sn, ss, sa, d1, isy, irq;
  logic [10:0] bs, bl;
  logic [11:0] tx;
  int          fails = 0;
  int          num_checks = 0;
  int          cyc = 0;
  wire  [31:0] rep = {28'h0, sd, sn, ss, sa};
  usb_in_endpoint_descriptor uut (
    .i_clk_sys(clk), .i_rstn(rstn), .i_ce(1'b1), .i_paddr(pa), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pw), .i_pwdata(wd), .i_pstrb(4'hF), .o_prdata(prd),
    .o_pready(prdy), .o_pslverr(perr), .i_in_token(tk), .i_setup_token(st),
    .i_in_ack(ak), .i_iso_overflow(ov), .o_send_data(sd), .o_send_nack(sn),
    .o_send_stall(ss), .o_setup_accept(sa), .o_data1(d1), .o_buf_is_y(isy),
    .o_buf_start(bs), .o_buf_length(bl), .o_tx_bytes(tx), .o_irq(irq));
  usb_host_model host (.i_clk_sys(clk), .o_in_token(tk), .o_setup_token(st),
    .o_in_ack(ak), .o_iso_overflow(ov));
  // 125 MHz clock and hang limit
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // apb transfer held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pw   <= w;
    pa   <= a;
    wd   <= d;
    @(posedge clk);
    pen  <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd   = prd;
    err  = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  // token pulse, reply sampled while it stands
  task automatic token(input int k);
    host.pulse(k);
    #1;
  endtask
  task automatic t_regs();
    rchk("setup rst", `IEP_OFS_SETUP, 32'h0);
    wr(`IEP_OFS_SIZE, 32'h18);
    rchk("size", `IEP_OFS_SIZE, 32'h18);
    chk("length", 32'h0C0, 32'(bl));
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    $display("test regs done");
  endtask
  task automatic t_dual();
    token(0);
    chk("off reply", 32'h0, rep);
    token(1);
    chk("setup reply", 32'h1, rep);
    wr(`IEP_OFS_XBASE, 32'h10);
    wr(`IEP_OFS_YBASE, 32'h20);
    wr(`IEP_OFS_XCOUNT, 32'h05);
    wr(`IEP_OFS_YCOUNT, 32'h03);
    wr(`IEP_OFS_MASK, 32'h1);
    wr(`IEP_OFS_SETUP, 32'h94);
    token(0);
    chk("x reply", 32'h8, rep);
    chk("x pid", 32'h0, 32'(d1));
    chk("x start", 32'h080, 32'(bs));
    chk("x bytes", 32'h5, 32'(tx));
    host.pulse(2);
    #1;
    chk("irq", 32'h1, 32'(irq));
    token(0);
    chk("y pid", 32'h1, 32'(d1));
    chk("y used", 32'h1, 32'(isy));
    chk("y start", 32'h100, 32'(bs));
    rchk("toggle", `IEP_OFS_SETUP, 32'hB4);
    wr(`IEP_OFS_STATUS, 32'h1);
    #1;
    chk("irq clr", 32'h0, 32'(irq));
    $display("test dual done");
  endtask
  task automatic t_single();
    wr(`IEP_OFS_SETUP, 32'h0);
    wr(`IEP_OFS_SETUP, 32'h80);
    token(0);
    chk("empty reply", 32'h4, rep);
    wr(`IEP_OFS_XCOUNT, 32'h07);
    wr(`IEP_OFS_SETUP, 32'h83);
    token(0);
    chk("x only", 32'h0, 32'(isy));
    chk("rsvd reply", 32'h8, rep);
    wr(`IEP_OFS_SETUP, 32'h88);
    token(0);
    chk("stall", 32'h2, rep);
    $display("test single done");
  endtask
  task automatic t_iso();
    wr(`IEP_OFS_XCOUNT, 32'h82);
    wr(`IEP_OFS_SETUP, 32'hC3);
    token(0);
    chk("iso reply", 32'h8, rep);
    chk("iso bytes", 32'h8, 32'(tx));
    chk("iso pid", 32'h0, 32'(d1));
    host.pulse(3);
    token(0);
    chk("iso y bytes", 32'hC, 32'(tx));
    rchk("overrun", `IEP_OFS_SETUP, 32'hE3);
    wr(`IEP_OFS_SETUP, 32'hE3);
    rchk("overrun kept", `IEP_OFS_SETUP, 32'hE3);
    wr(`IEP_OFS_SETUP, 32'hDF);
    rchk("overrun clr", `IEP_OFS_SETUP, 32'hDF);
    token(0);
    chk("bps max", 32'h40, 32'(tx));
    $display("test iso done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_dual();
    t_single();
    t_iso();
    test_done();
  end
endmodule // testbench
